// file: verilog/oau_pkg.sv
// constants and types for the operand address unit
//
// Contract
// - specifier bits 5:3 give the addressing mode.
// - specifier bits 2:0 select one of eight general registers.
// - first word: opcode 15:12, source 11:6, destination 5:0.
// - specifier bit 3 set means deferred: one extra address read; the code makes no read for mode 1.
// - mode 0 uses the register itself; byte ops use low byte.
// - mode 1 uses register contents as operand address.
// - mode 2 uses register as address, then adds 1 byte, 2 word.
// - stack pointer and program counter always step by 2.
// - mode 3 reads address at register, then adds 2.
// - autodecrement subtracts 1 byte or 2 word first, then uses it.
// - autodecrement deferred subtracts 2, then reads the address there.
// - mode 6 adds the following index word to the register.
// - index mode leaves register and index word unchanged.
// - mode 7 adds index word, then reads operand address there.
// - register 6 is stack pointer, register 7 program counter.
// - every fetch through the program counter adds two to it.
package oau_pkg;
    localparam int WORD_W = 16;
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 12;
    localparam int SRC_HI = 11;
    localparam int SRC_LO = 6;
    localparam int DST_HI = 5;
    localparam int DST_LO = 0;
    localparam int MODE_HI = 5;
    localparam int MODE_LO = 3;
    localparam int REG_HI = 2;
    localparam int REG_LO = 0;
    localparam int DEFER_BIT = 3;
    localparam logic [2:0] MODE_REG = 3'h0;
    localparam logic [2:0] MODE_REG_DEF = 3'h1;
    localparam logic [2:0] MODE_AINC = 3'h2;
    localparam logic [2:0] MODE_AINC_DEF = 3'h3;
    localparam logic [2:0] MODE_ADEC = 3'h4;
    localparam logic [2:0] MODE_ADEC_DEF = 3'h5;
    localparam logic [2:0] MODE_INDEX = 3'h6;
    localparam logic [2:0] MODE_INDEX_DEF = 3'h7;
    localparam logic [2:0] STACK_POINTER_REGISTER = 3'h6;
    localparam logic [2:0] PROGRAM_COUNTER_REGISTER = 3'h7;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] REG_RESET = 16'h0000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_INDEX = 2'b01,
        ST_DEFER = 2'b10
    } oau_state_t;
endpackage : oau_pkg

// file: verilog/oau_rf_if.sv
// register file access bundle between sequencer and register file
`timescale 1ns/100ps
interface oau_rf_if;
    logic [2:0] rsel;
    logic [15:0] rdata;
    logic [15:0] pc;
    logic we;
    logic [2:0] wsel;
    logic [15:0] wdata;
    modport ctl (output rsel, output we, output wsel, output wdata,
                 input rdata, input pc);
    modport rf (input rsel, input we, input wsel, input wdata,
                output rdata, output pc);
endinterface : oau_rf_if

// file: verilog/oau_regfile.sv
// eight general registers, one read port, one write port, pc tap
`timescale 1ns/100ps
module oau_regfile #(
    parameter int NREG = 8
) (
    // clock and control
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // access bundle
    oau_rf_if.rf bus
);
    logic [15:0] regs_q [NREG];

    assign bus.rdata = regs_q[bus.rsel];
    // pc tap lets index fetches run beside a general register read
    assign bus.pc = regs_q[oau_pkg::PROGRAM_COUNTER_REGISTER];

    for (genvar i = 0; i < NREG; i++) begin : g_reg
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                regs_q[i] <= oau_pkg::REG_RESET;
            end else if (clk_en && bus.we && bus.wsel == 3'(i)) begin
                regs_q[i] <= bus.wdata;
            end
        end
    end
endmodule : oau_regfile

// file: verilog/oau_operand_unit.sv
// operand address sequencer: decode, address arithmetic, reads
`timescale 1ns/100ps
module oau_operand_unit (
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // specifier request
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic sel_dst,
    input wire logic byte_op,
    // external register write, taken only while idle
    input wire logic ext_we,
    input wire logic [2:0] ext_wsel,
    input wire logic [15:0] ext_wdata,
    // memory read port
    output logic rd_req,
    output logic [15:0] rd_addr,
    input wire logic rd_ack,
    input wire logic [15:0] rd_data,
    // result
    output logic busy,
    output logic done,
    output logic [15:0] ea,
    output logic operand_is_reg,
    output logic operand_low_byte,
    output logic [3:0] opcode
);
    oau_rf_if rf_bus ();

    oau_regfile #(.NREG(8)) u_rf (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .bus(rf_bus)
    );

    oau_pkg::oau_state_t state_q;
    logic [2:0] mode_q;
    logic [2:0] rn_q;
    logic rd_req_q;
    logic [15:0] rd_addr_q;
    logic done_q;
    logic [15:0] ea_q;
    logic is_reg_q;
    logic low_byte_q;
    logic [3:0] opcode_q;
    logic busy_q;
    oau_pkg::oau_state_t state_d;
    logic rd_req_d;
    logic [15:0] rd_addr_d;
    logic done_d;
    logic [15:0] ea_d;

    // specifier decode
    wire [5:0] spec = sel_dst ? instr[oau_pkg::DST_HI:oau_pkg::DST_LO]
                              : instr[oau_pkg::SRC_HI:oau_pkg::SRC_LO];
    wire [2:0] spec_mode = spec[oau_pkg::MODE_HI:oau_pkg::MODE_LO];
    wire [2:0] spec_rn = spec[oau_pkg::REG_HI:oau_pkg::REG_LO];
    wire spec_defer = spec[oau_pkg::DEFER_BIT];
    wire idle = state_q == oau_pkg::ST_IDLE;
    wire take = idle && start;

    // step size: sp and pc never step by one, deferred always by two
    wire sp_or_pc = spec_rn >= oau_pkg::STACK_POINTER_REGISTER;
    wire [15:0] step = (byte_op && !sp_or_pc && !spec_defer)
                       ? oau_pkg::STEP_BYTE : oau_pkg::STEP_WORD;
    wire [15:0] inc_val = rf_bus.rdata + step;
    wire [15:0] dec_val = rf_bus.rdata - step;

    // index arithmetic sees the pc already past the index word
    wire [15:0] pc_next = rf_bus.pc + oau_pkg::STEP_WORD;
    wire rn_is_pc = rn_q == oau_pkg::PROGRAM_COUNTER_REGISTER;
    wire [15:0] base = rn_is_pc ? pc_next : rf_bus.rdata;
    wire [15:0] index_sum = base + rd_data;
    wire index_ack = state_q == oau_pkg::ST_INDEX && rd_req_q && rd_ack;
    wire defer_ack = state_q == oau_pkg::ST_DEFER && rd_req_q && rd_ack;

    // register write-back selection
    wire step_mode = spec_mode inside {oau_pkg::MODE_AINC,
        oau_pkg::MODE_AINC_DEF, oau_pkg::MODE_ADEC, oau_pkg::MODE_ADEC_DEF};
    wire is_dec = spec_mode[2];
    wire wr_step = take && step_mode;
    assign rf_bus.rsel = idle ? spec_rn : rn_q;
    assign rf_bus.we = wr_step || index_ack || (idle && !start && ext_we);
    assign rf_bus.wsel = wr_step ? spec_rn
                       : index_ack ? oau_pkg::PROGRAM_COUNTER_REGISTER
                       : ext_wsel;
    assign rf_bus.wdata = wr_step ? (is_dec ? dec_val : inc_val)
                        : index_ack ? pc_next
                        : ext_wdata;

    // next state and read request; every transition sits in this one case
    always_comb begin
        state_d = state_q;
        rd_req_d = rd_req_q;
        rd_addr_d = rd_addr_q;
        done_d = 1'b0;
        ea_d = ea_q;
        case (state_q)
            oau_pkg::ST_IDLE: begin
                if (start) begin
                    case (spec_mode)
                        oau_pkg::MODE_REG: begin
                            ea_d = {13'h0000, spec_rn};
                            done_d = 1'b1;
                        end
                        oau_pkg::MODE_REG_DEF,
                        oau_pkg::MODE_AINC: begin
                            ea_d = rf_bus.rdata;
                            done_d = 1'b1;
                        end
                        oau_pkg::MODE_AINC_DEF: begin
                            rd_addr_d = rf_bus.rdata;
                            rd_req_d = 1'b1;
                            state_d = oau_pkg::ST_DEFER;
                        end
                        oau_pkg::MODE_ADEC: begin
                            ea_d = dec_val;
                            done_d = 1'b1;
                        end
                        oau_pkg::MODE_ADEC_DEF: begin
                            rd_addr_d = dec_val;
                            rd_req_d = 1'b1;
                            state_d = oau_pkg::ST_DEFER;
                        end
                        default: begin
                            rd_addr_d = rf_bus.pc;
                            rd_req_d = 1'b1;
                            state_d = oau_pkg::ST_INDEX;
                        end
                    endcase
                end
            end
            oau_pkg::ST_INDEX: begin
                if (index_ack) begin
                    rd_req_d = 1'b0;
                    if (mode_q[0]) begin
                        // request drops one cycle between the two reads
                        rd_addr_d = index_sum;
                        state_d = oau_pkg::ST_DEFER;
                    end else begin
                        ea_d = index_sum;
                        done_d = 1'b1;
                        state_d = oau_pkg::ST_IDLE;
                    end
                end
            end
            oau_pkg::ST_DEFER: begin
                if (defer_ack) begin
                    rd_req_d = 1'b0;
                    ea_d = rd_data;
                    done_d = 1'b1;
                    state_d = oau_pkg::ST_IDLE;
                end else if (!rd_req_q) begin
                    rd_req_d = 1'b1;
                end
            end
            default: begin
                state_d = oau_pkg::ST_IDLE;
            end
        endcase
    end

    // busy is registered from the next state so the port comes off a flop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= oau_pkg::ST_IDLE;
            busy_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            busy_q <= state_d != oau_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_req_q <= 1'b0;
            rd_addr_q <= 16'h0000;
        end else if (clk_en) begin
            rd_req_q <= rd_req_d;
            rd_addr_q <= rd_addr_d;
        end
    end

    // ea and done move only on enabled edges, so a freeze holds them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_q <= 1'b0;
            ea_q <= 16'h0000;
        end else if (clk_en) begin
            done_q <= done_d;
            ea_q <= ea_d;
        end
    end

    // request fields are captured only on the taking edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= oau_pkg::MODE_REG;
            rn_q <= 3'h0;
            opcode_q <= 4'h0;
            is_reg_q <= 1'b0;
            low_byte_q <= 1'b0;
        end else if (clk_en && take) begin
            mode_q <= spec_mode;
            rn_q <= spec_rn;
            opcode_q <= instr[oau_pkg::OPC_HI:oau_pkg::OPC_LO];
            is_reg_q <= spec_mode == oau_pkg::MODE_REG;
            low_byte_q <= byte_op && spec_mode == oau_pkg::MODE_REG;
        end
    end

    assign rd_req = rd_req_q;
    assign rd_addr = rd_addr_q;
    assign busy = busy_q;
    assign done = done_q;
    assign ea = ea_q;
    assign operand_is_reg = is_reg_q;
    assign operand_low_byte = low_byte_q;
    assign opcode = opcode_q;
endmodule : oau_operand_unit

// file: bench/oau_mem_model.sv
// memory and i/o read responder with random latency
`timescale 1ns/100ps
module oau_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // read port
    input wire logic rd_req,
    input wire logic [15:0] rd_addr,
    output logic rd_ack,
    output logic [15:0] rd_data
);
    logic [1:0] wait_q = 2'h0;
    // data outside the ack cycle is inverted so stale words never match
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_ack <= 1'b0;
            rd_data <= 16'hffff;
        end else if (rd_ack || !rd_req) begin
            rd_ack <= 1'b0;
            rd_data <= ~rd_data;
            wait_q <= 2'($urandom_range(3, 0));
        end else if (wait_q == 2'h0) begin
            rd_ack <= 1'b1;
            rd_data <= rd_addr ^ 16'h5a5a;
        end else begin
            wait_q <= wait_q - 2'h1;
            rd_data <= ~rd_data;
        end
    end
endmodule : oau_mem_model

// file: bench/oau_operand_checker.sv
// port-level assertions for the operand address unit
`timescale 1ns/100ps
module oau_operand_checker (
    // clock and control
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // request
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic sel_dst,
    input wire logic byte_op,
    // memory and result
    input wire logic rd_req,
    input wire logic [15:0] rd_addr,
    input wire logic rd_ack,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] ea,
    input wire logic operand_is_reg,
    input wire logic operand_low_byte,
    input wire logic [3:0] opcode
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [5:0] spec_w = sel_dst ? instr[5:0] : instr[11:6];
    wire [2:0] mode_w = spec_w[5:3];
    wire [2:0] reg_w = spec_w[2:0];
    wire [3:0] opc_w = instr[15:12];
    wire take_w = clk_en && start && !busy;
    wire rd_mode_w = mode_w inside {3'h3, 3'h5, 3'h6, 3'h7};
    property p_fast; take_w && !rd_mode_w |=> done && !rd_req
        && (operand_is_reg == ($past(mode_w) == 3'h0)); endproperty
    a_fast: assert property (p_fast) else $error("fast mode");
    property p_read; take_w && rd_mode_w |=> rd_req && !done; endproperty
    a_read: assert property (p_read) else $error("no read");
    property p_reg_ea; take_w && mode_w == 3'h0
        |=> ea == {13'h0000, $past(reg_w)}; endproperty
    a_reg_ea: assert property (p_reg_ea) else $error("reg ea");
    property p_opcode; take_w |=> opcode == $past(opc_w); endproperty
    a_opcode: assert property (p_opcode) else $error("opcode");
    property p_pulse; done |=> !done; endproperty
    a_pulse: assert property (p_pulse) else $error("done width");
    property p_hold; rd_req && !rd_ack |=> rd_req && $stable(rd_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("read hold");
    property p_drop; rd_req && rd_ack && clk_en |=> !rd_req; endproperty
    a_drop: assert property (p_drop) else $error("read drop");
    // bound covers two reads with the slowest responder latency
    property p_bound; take_w && rd_mode_w |-> ##[3:40] done; endproperty
    a_bound: assert property (p_bound) else $error("no done");
    property p_low_byte; take_w |=> operand_low_byte
        == ($past(byte_op) && $past(mode_w) == 3'h0); endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte");
    // a frozen edge must leave done, busy, ea, the read request and its address untouched
    property p_freeze; !clk_en |=> $stable(done) && $stable(busy)
        && $stable(rd_req) && $stable(rd_addr) && $stable(ea); endproperty
    a_freeze: assert property (p_freeze) else $error("freeze");
endmodule : oau_operand_checker
bind oau_operand_unit oau_operand_checker u_chk (.clk(clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .start(start), .instr(instr),
    .sel_dst(sel_dst), .byte_op(byte_op), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_ack(rd_ack), .busy(busy), .done(done),
    .ea(ea), .operand_is_reg(operand_is_reg),
    .operand_low_byte(operand_low_byte), .opcode(opcode));

// file: bench/testbench.sv
// self-checking bench for the operand address unit
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, start = 1'b0;
    logic sel_dst = 1'b0, byte_op = 1'b0, ext_we = 1'b0;
    logic [15:0] instr = 16'h0000, ext_wdata = 16'h0000, rd_addr, rd_data, ea;
    logic [2:0] ext_wsel = 3'h0;
    logic rd_req, rd_ack, busy, done, operand_is_reg, operand_low_byte;
    logic [3:0] opcode;
    logic [15:0] exp_r [8] = '{default: 16'h0000};
    int errors = 0, compares = 0;
    always #5 clk = ~clk;
    oau_operand_unit DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .start(start), .instr(instr), .sel_dst(sel_dst), .byte_op(byte_op),
        .ext_we(ext_we), .ext_wsel(ext_wsel), .ext_wdata(ext_wdata),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
        .rd_data(rd_data), .busy(busy), .done(done), .ea(ea),
        .operand_is_reg(operand_is_reg),
        .operand_low_byte(operand_low_byte), .opcode(opcode));
    oau_mem_model u_mem (.clk(clk), .sys_rst(sys_rst), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data));
    task automatic wrap_up;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        compares++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic set_reg(input logic [2:0] n, input logic [15:0] v);
        @(posedge clk);
        #1;
        {ext_we, ext_wsel, ext_wdata} = {1'b1, n, v};
        exp_r[n] = v;
        @(posedge clk);
        #1;
        ext_we = 1'b0;
    endtask : set_reg
    // expected address and register steps worked out before the request
    task automatic run(input logic [15:0] ins, input logic sd, input logic bo);
        logic [5:0] s;
        logic [15:0] st, e, x;
        logic frz;
        int n;
        s = sd ? ins[5:0] : ins[11:6];
        st = (bo && s[2:1] != 2'b11 && !s[3]) ? 16'h1 : 16'h2;
        x = 16'h0000;
        if (s[5:4] == 2'b10) exp_r[s[2:0]] -= st;
        if (s[5:4] == 2'b11) x = exp_r[7] ^ 16'h5a5a;
        if (s[5:4] == 2'b11) exp_r[7] += 16'h2;
        e = (s[5:3] == 3'h0) ? {13'h0, s[2:0]} : exp_r[s[2:0]] + x;
        if (s[5:4] == 2'b01) exp_r[s[2:0]] += st;
        if (s[3] && s[5:3] != 3'h1) e = e ^ 16'h5a5a;
        @(posedge clk);
        #1;
        {instr, sel_dst, byte_op, start} = {ins, sd, bo, 1'b1};
        // read modes keep start up while busy; it must be ignored
        repeat ((s[3] && s[5:3] != 3'h1) || s[5:3] == 3'h6 ? 2 : 1)
            @(posedge clk);
        #1;
        start = 1'b0;
        frz = 1'($urandom);
        // one frozen edge at most, so read latency stays inside the bound
        for (n = 0; n < 50 && done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            clk_en = n != 0 || !frz || done === 1'b1;
        end
        if (n == 50) errors++;
        if (n == 50) wrap_up();
        check(ea, e);
        check(16'(operand_is_reg), 16'(s[5:3] == 3'h0));
        check(16'(operand_low_byte), 16'(s[5:3] == 3'h0 && bo));
        check(16'(opcode), 16'(ins[15:12]));
    endtask : run
    initial begin
        void'($urandom(64));
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        run(16'h100b, 1'b1, 1'b0);
        for (int i = 0; i < 8; i++)
            set_reg(3'(i), 16'(16'h0100 * i + 16'h0011));
        for (int m = 0; m < 24; m++)
            run({4'(m), 6'h00, 3'(m / 3), 3'(m % 3 ? m % 3 + 5 : 0)}, 1'b1, 1'b1);
        for (int i = 0; i < 400; i++) begin
            if ($urandom_range(5, 0) == 0) set_reg(3'($urandom), 16'($urandom));
            run(16'($urandom), 1'($urandom), 1'($urandom));
        end
        wrap_up();
    end
endmodule : testbench
